// [logic/dpc_pkg.sv]
// Shared constants of the digital path configuration bank.
// Assumes one clock domain and 32-bit AXI4-Lite register access.
package dpc_pkg;

   // Bus geometry and responses
   localparam int          ADDR_W      = 8;
   localparam int          DATA_W      = 32;
   localparam int          PAT_W       = 20;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // Register indices; byte address is four times the index
   localparam logic [5:0]  IDX_PAT_LOW  = 6'h20;
   localparam logic [5:0]  IDX_PAT_MID  = 6'h21;
   localparam logic [5:0]  IDX_PAT_HIGH = 6'h22;
   localparam logic [5:0]  IDX_CTRL     = 6'h24;
   localparam logic [5:0]  IDX_DEC      = 6'h25;
   localparam logic [5:0]  IDX_NCO_A    = 6'h30;
   localparam logic [5:0]  IDX_NCO_B    = 6'h31;

   // Reset values
   localparam logic [7:0]  BYTE_RESET = 8'h00;
   localparam logic [31:0] NCO_RESET  = 32'h0000_0000;
   localparam logic [31:0] NCO_ZERO   = 32'h0000_0000;

   // Field positions of digital_path_control
   localparam int CTRL_AVG    = 5;
   localparam int CTRL_SEL_HI = 4;
   localparam int CTRL_SEL_LO = 3;
   localparam int CTRL_INCL   = 2;
   localparam int CTRL_DEC_EN = 1;

   // Field positions of decimation_config
   localparam int DEC_MUX_EN   = 7;
   localparam int DEC_RATIO_HI = 6;
   localparam int DEC_RATIO_LO = 4;
   localparam int DEC_REAL     = 3;
   localparam int DEC_PHASE    = 0;
   localparam int PAT_HIGH_W   = 4;

   // Downconverter input selector codes
   typedef enum logic [1:0] {
      SEL_DIRECT  = 2'b00,
      SEL_A_BOTH  = 2'b01,
      SEL_B_BOTH  = 2'b10,
      SEL_AVERAGE = 2'b11
   } dpc_sel_t;

   // Decimation ratio codes
   typedef enum logic [2:0] {
      RATIO_BYPASS = 3'b000,
      RATIO_2      = 3'b001,
      RATIO_4      = 3'b010,
      RATIO_8      = 3'b011,
      RATIO_16     = 3'b100,
      RATIO_32     = 3'b101
   } dpc_ratio_t;

   // Output resolution codes
   typedef enum logic [1:0] {
      RES_14 = 2'b00,
      RES_16 = 2'b01,
      RES_18 = 2'b10,
      RES_20 = 2'b11
   } dpc_res_t;

   // Frame patterns chosen by hardware in decimation bypass
   localparam logic [19:0] PAT_AUTO_14 = 20'hFE000;
   localparam logic [19:0] PAT_AUTO_16 = 20'hFF000;
   localparam logic [19:0] PAT_AUTO_18 = 20'hFF800;
   localparam logic [19:0] PAT_AUTO_20 = 20'hFFC00;

endpackage : dpc_pkg

// [logic/dpc_input_router.sv]
// Converter-to-downconverter routing, channel averaging and path bypass.
// Assumes converter samples arrive on core_clk, signed two's complement.
`timescale 1ns/10ps
module dpc_input_router #(
   parameter int W = 14
) (
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   // Configuration levels
   input  wire logic                muxEnable,
   input  wire logic [1:0]          selCode,
   input  wire logic                avgEnable,
   input  wire logic                pathInclude,
   // Converter samples
   input  wire logic signed [W-1:0] adcA,
   input  wire logic signed [W-1:0] adcB,
   // Routed samples
   output logic signed [W-1:0]      ddcInA,
   output logic signed [W-1:0]      ddcInB
);

   logic signed [W:0]   sumAB;
   logic signed [W-1:0] avgOut;
   logic signed [W-1:0] selA;
   logic signed [W-1:0] selB;

   // Sum kept one bit wider so the halving never overflows
   assign sumAB  = W'(0) + {adcA[W-1], adcA} + {adcB[W-1], adcB};
   assign avgOut = avgEnable ? sumAB[W:1] : adcA;

   // Selector acts only with the mux enabled, else straight through
   always_comb begin
      selA = adcA;
      selB = adcB;
      if (muxEnable) begin
         unique case (dpc_pkg::dpc_sel_t'(selCode))
            dpc_pkg::SEL_DIRECT: begin
               selA = adcA;
               selB = adcB;
            end
            dpc_pkg::SEL_A_BOTH: begin
               selA = adcA;
               selB = adcA;
            end
            dpc_pkg::SEL_B_BOTH: begin
               selA = adcB;
               selB = adcB;
            end
            dpc_pkg::SEL_AVERAGE: begin
               selA = avgOut;
               selB = avgOut;
            end
         endcase
      end
   end

   // Bypass skips the feature path; both routes pass through the same single register stage
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ddcInA <= '0;
         ddcInB <= '0;
      end else begin
         ddcInA <= pathInclude ? selA : adcA;
         ddcInB <= pathInclude ? selB : adcB;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_mux_off_direct: assert property (
      !muxEnable |=> ddcInA == $past(adcA) && ddcInB == $past(adcB))
      else $error("disabled mux did not pass channels straight");
   a_average_value: assert property (
      pathInclude && muxEnable && avgEnable && selCode == 2'b11
      |=> ddcInB == W'(($past(sumAB)) >>> 1))
      else $error("average is not half the sum");
   a_sel_a_both: assert property (
      pathInclude && muxEnable && selCode == 2'b01
      |=> ddcInA == $past(adcA) && ddcInB == $past(adcA))
      else $error("selector code 01 did not copy A");
   a_path_bypass: assert property (
      !pathInclude && muxEnable && selCode == 2'b10
      |=> ddcInA == $past(adcA))
      else $error("bypass did not route around features");

endmodule : dpc_input_router

// [logic/dpc_frame_pattern.sv]
// Frame clock pattern choice: programmed value or automatic in bypass.
// Assumes the resolution code is a same-clock level.
`timescale 1ns/10ps
module dpc_frame_pattern (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Selection
   input  wire logic [19:0] progPattern,
   input  wire logic        decBypass,
   input  wire logic [1:0]  resolution,
   // Pattern to the serializer
   output logic [19:0]      framePattern
);

   logic [19:0] autoPattern;

   // Hardware picks the pattern per resolution in bypass
   always_comb begin
      unique case (dpc_pkg::dpc_res_t'(resolution))
         dpc_pkg::RES_14: autoPattern = dpc_pkg::PAT_AUTO_14;
         dpc_pkg::RES_16: autoPattern = dpc_pkg::PAT_AUTO_16;
         dpc_pkg::RES_18: autoPattern = dpc_pkg::PAT_AUTO_18;
         dpc_pkg::RES_20: autoPattern = dpc_pkg::PAT_AUTO_20;
      endcase
   end

   // Registered so the serializer sees a clean level
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         framePattern <= '0;
      end else begin
         framePattern <= decBypass ? autoPattern : progPattern;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_pattern_prog: assert property (
      !decBypass |=> framePattern == $past(progPattern))
      else $error("programmed pattern not applied");
   a_pattern_auto: assert property (
      decBypass && resolution == 2'b01 |=> framePattern == 20'hFF000)
      else $error("bypass pattern not chosen by hardware");

endmodule : dpc_frame_pattern

// [logic/dpc_config_bank.sv]
// Configuration bank of the digital feature path with AXI4-Lite access.
// Assumes converters, bus and downstream filters share core_clk.
`timescale 1ns/10ps

// Overview of operation
// - A 20-bit frame clock pattern in three byte registers sets duty cycle.
// - In decimation bypass hardware picks the pattern from output resolution.
// - Average enable makes the averaging block output (A+B)/2.
// - Selector 00 straight, 01 A to both, 10 B to both, 11 average.
// - Path include 0 routes around features; 1 passes through them.
// - One decimator enable bit turns both channels' filters on or off.
// - Selector takes effect only while the mux enable bit is set.
// - Three-bit ratio: 000 bypass, 001 to 101 decimate by 2 to 32.
// - Real-output bit 1 gives real decimation, 0 complex, both channels.
// - Phase-invert bit inverts the oscillator phase; 0 leaves it unchanged.
// - A 32-bit oscillator word per channel, forced to zero in real mode.
module dpc_config_bank #(
   parameter int ADC_W   = 14,
   parameter int PHASE_W = 16
) (
   // Clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    rst_n,
   // AXI4-Lite write address and data
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [7:0]              s_axi_awaddr,
   input  wire logic [2:0]              s_axi_awprot,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   // AXI4-Lite write response
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   output logic [1:0]                   s_axi_bresp,
   // AXI4-Lite read
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   input  wire logic [7:0]              s_axi_araddr,
   input  wire logic [2:0]              s_axi_arprot,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   // Converter samples and downconverter inputs
   input  wire logic signed [ADC_W-1:0] adcA,
   input  wire logic signed [ADC_W-1:0] adcB,
   output logic signed [ADC_W-1:0]      ddcInA,
   output logic signed [ADC_W-1:0]      ddcInB,
   // Feature path controls
   output logic                         pathInclude,
   output logic                         decimatorEnable,
   output logic [2:0]                   decimationRatio,
   output logic                         decimationBypass,
   output logic                         realDecimation,
   // Oscillator
   output logic [31:0]                  ncoWordA,
   output logic [31:0]                  ncoWordB,
   input  wire logic [PHASE_W-1:0]      ncoPhaseIn,
   output logic [PHASE_W-1:0]           ncoPhaseOut,
   // Frame clock
   input  wire logic [1:0]              outputResolution,
   output logic [19:0]                  framePattern
);

   logic [7:0]  patLow_reg;
   logic [7:0]  patMid_reg;
   logic [7:0]  patHigh_reg;
   logic [7:0]  ctrl_reg;
   logic [7:0]  dec_reg;
   logic [31:0] ncoA_reg;
   logic [31:0] ncoB_reg;
   logic [5:0]  wrIdx;
   logic [5:0]  rdIdx;
   logic        wrTake;
   logic        rdTake;
   logic        wrHit;
   logic [31:0] rdData_next;
   logic        rdHit_next;
   logic [2:0]  ratioCode;
   logic        ratioLegal;

   // One write and one read at a time; no new take until the answer leaves
   assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_wready  = s_axi_awready;
   assign s_axi_arready = !s_axi_rvalid;
   assign wrTake        = s_axi_awready;
   assign rdTake        = s_axi_arvalid && s_axi_arready;
   assign wrIdx         = s_axi_awaddr[7:2];
   assign rdIdx         = s_axi_araddr[7:2];

   // Address decode of writes
   always_comb begin
      unique case (wrIdx)
         dpc_pkg::IDX_PAT_LOW, dpc_pkg::IDX_PAT_MID, dpc_pkg::IDX_PAT_HIGH,
         dpc_pkg::IDX_CTRL, dpc_pkg::IDX_DEC,
         dpc_pkg::IDX_NCO_A, dpc_pkg::IDX_NCO_B: wrHit = 1'b1;
         default: wrHit = 1'b0;
      endcase
   end

   // Byte registers; reserved bits are stored like any other bit
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         patLow_reg  <= dpc_pkg::BYTE_RESET;
         patMid_reg  <= dpc_pkg::BYTE_RESET;
         patHigh_reg <= dpc_pkg::BYTE_RESET;
         ctrl_reg    <= dpc_pkg::BYTE_RESET;
         dec_reg     <= dpc_pkg::BYTE_RESET;
      end else if (wrTake && s_axi_wstrb[0]) begin
         if (wrIdx == dpc_pkg::IDX_PAT_LOW) patLow_reg <= s_axi_wdata[7:0];
         if (wrIdx == dpc_pkg::IDX_PAT_MID) patMid_reg <= s_axi_wdata[7:0];
         if (wrIdx == dpc_pkg::IDX_PAT_HIGH) patHigh_reg <= s_axi_wdata[7:0];
         if (wrIdx == dpc_pkg::IDX_CTRL) ctrl_reg <= s_axi_wdata[7:0];
         if (wrIdx == dpc_pkg::IDX_DEC) dec_reg <= s_axi_wdata[7:0];
      end
   end

   // Oscillator words, byte lanes honoured
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ncoA_reg <= dpc_pkg::NCO_RESET;
         ncoB_reg <= dpc_pkg::NCO_RESET;
      end else if (wrTake) begin
         for (int i = 0; i < 4; i++) begin
            if (s_axi_wstrb[i] && wrIdx == dpc_pkg::IDX_NCO_A) begin
               ncoA_reg[8*i +: 8] <= s_axi_wdata[8*i +: 8];
            end
            if (s_axi_wstrb[i] && wrIdx == dpc_pkg::IDX_NCO_B) begin
               ncoB_reg[8*i +: 8] <= s_axi_wdata[8*i +: 8];
            end
         end
      end
   end

   // Write response, unmapped offsets answer SLVERR
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= dpc_pkg::RESP_OKAY;
      end else if (wrTake) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wrHit ? dpc_pkg::RESP_OKAY : dpc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read mux; oscillator words read back as they are applied
   always_comb begin
      rdData_next = '0;
      rdHit_next  = 1'b1;
      unique case (rdIdx)
         dpc_pkg::IDX_PAT_LOW:  rdData_next[7:0] = patLow_reg;
         dpc_pkg::IDX_PAT_MID:  rdData_next[7:0] = patMid_reg;
         dpc_pkg::IDX_PAT_HIGH: rdData_next[7:0] = patHigh_reg;
         dpc_pkg::IDX_CTRL:     rdData_next[7:0] = ctrl_reg;
         dpc_pkg::IDX_DEC:      rdData_next[7:0] = dec_reg;
         dpc_pkg::IDX_NCO_A:    rdData_next      = ncoWordA;
         dpc_pkg::IDX_NCO_B:    rdData_next      = ncoWordB;
         default:               rdHit_next       = 1'b0;
      endcase
   end

   // Read answer held until the master takes it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= dpc_pkg::RESP_OKAY;
      end else if (rdTake) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rdData_next;
         s_axi_rresp  <= rdHit_next ? dpc_pkg::RESP_OKAY
                                    : dpc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Ratio decode; unused codes fall back to bypass for safety
   assign ratioCode  = dec_reg[dpc_pkg::DEC_RATIO_HI:dpc_pkg::DEC_RATIO_LO];
   assign ratioLegal = ratioCode <= dpc_pkg::RATIO_32;

   // Control levels to the filters, registered
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pathInclude      <= 1'b0;
         decimatorEnable  <= 1'b0;
         decimationRatio  <= dpc_pkg::RATIO_BYPASS;
         decimationBypass <= 1'b1;
         realDecimation   <= 1'b0;
      end else begin
         pathInclude      <= ctrl_reg[dpc_pkg::CTRL_INCL];
         decimatorEnable  <= ctrl_reg[dpc_pkg::CTRL_DEC_EN];
         decimationRatio  <= ratioLegal ? ratioCode
                                        : dpc_pkg::RATIO_BYPASS;
         decimationBypass <= !ratioLegal
                             || ratioCode == dpc_pkg::RATIO_BYPASS;
         realDecimation   <= dec_reg[dpc_pkg::DEC_REAL];
      end
   end

   // Real mode saves power by zeroing the mixer word
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ncoWordA <= dpc_pkg::NCO_RESET;
         ncoWordB <= dpc_pkg::NCO_RESET;
      end else begin
         ncoWordA <= dec_reg[dpc_pkg::DEC_REAL] ? dpc_pkg::NCO_ZERO
                                                : ncoA_reg;
         ncoWordB <= dec_reg[dpc_pkg::DEC_REAL] ? dpc_pkg::NCO_ZERO
                                                : ncoB_reg;
      end
   end

   // Phase inversion is a plain bitwise complement
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ncoPhaseOut <= '0;
      end else begin
         ncoPhaseOut <= dec_reg[dpc_pkg::DEC_PHASE] ? ~ncoPhaseIn
                                                    : ncoPhaseIn;
      end
   end

   // Converter routing ahead of the downconverters
   dpc_input_router #(
      .W (ADC_W)
   ) u_router (
      .core_clk    (core_clk),
      .rst_n       (rst_n),
      .muxEnable   (dec_reg[dpc_pkg::DEC_MUX_EN]),
      .selCode     (ctrl_reg[dpc_pkg::CTRL_SEL_HI:dpc_pkg::CTRL_SEL_LO]),
      .avgEnable   (ctrl_reg[dpc_pkg::CTRL_AVG]),
      .pathInclude (ctrl_reg[dpc_pkg::CTRL_INCL]),
      .adcA        (adcA),
      .adcB        (adcB),
      .ddcInA      (ddcInA),
      .ddcInB      (ddcInB)
   );

   // Bypass also when the filters are off or the path is skipped
   dpc_frame_pattern u_frame (
      .core_clk     (core_clk),
      .rst_n        (rst_n),
      .progPattern  ({patHigh_reg[dpc_pkg::PAT_HIGH_W-1:0], patMid_reg,
                      patLow_reg}),
      .decBypass    (ratioCode == dpc_pkg::RATIO_BYPASS || !ratioLegal
                     || !ctrl_reg[dpc_pkg::CTRL_DEC_EN]
                     || !ctrl_reg[dpc_pkg::CTRL_INCL]),
      .resolution   (outputResolution),
      .framePattern (framePattern)
   );

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // Bus answers and register effects
   a_write_resp_next: assert property (
      wrTake |=> s_axi_bvalid && !s_axi_awready)
      else $error("write answer not one cycle after take");
   a_read_resp_next: assert property (
      rdTake |=> s_axi_rvalid && s_axi_rdata == $past(rdData_next))
      else $error("read answer wrong or late");
   a_read_unmapped: assert property (
      rdTake && !rdHit_next |=> s_axi_rresp == dpc_pkg::RESP_SLVERR)
      else $error("unmapped read not answered with error");
   a_nco_real_zero: assert property (
      dec_reg[dpc_pkg::DEC_REAL] [*2]
      |-> ncoWordA == 32'h0 && ncoWordB == 32'h0)
      else $error("oscillator word not zero in real mode");
   a_phase_invert: assert property (
      dec_reg[dpc_pkg::DEC_PHASE] |=> ncoPhaseOut == ~$past(ncoPhaseIn))
      else $error("phase not inverted");
   a_dec_enable: assert property (
      wrTake && s_axi_wstrb[0] && wrIdx == dpc_pkg::IDX_CTRL
      |-> ##2 decimatorEnable == $past(s_axi_wdata[1], 2))
      else $error("decimator enable does not follow its bit");
   a_ratio_bypass: assert property (
      ratioCode > 3'h5 |=> decimationBypass && decimationRatio == 3'h0)
      else $error("unused ratio code not treated as bypass");
   a_real_mode: assert property (
      $rose(dec_reg[dpc_pkg::DEC_REAL]) |=> realDecimation)
      else $error("real decimation not reported");
   a_ctrl_stored: assert property (
      wrTake && s_axi_wstrb[0] && wrIdx == dpc_pkg::IDX_CTRL
      |=> ctrl_reg == $past(s_axi_wdata[7:0]))
      else $error("control byte not stored whole");

   // Main scenarios; the bench reaches all but the oscillator word read
   c_write_ctrl: cover property (wrTake && wrIdx == dpc_pkg::IDX_CTRL);
   c_real_mode: cover property (realDecimation && ncoWordA == 32'h0);
   c_read_nco: cover property (rdTake && rdIdx == dpc_pkg::IDX_NCO_A);
   c_average_path: cover property (ctrl_reg[dpc_pkg::CTRL_AVG]
                                   && dec_reg[dpc_pkg::DEC_MUX_EN]);
   c_unmapped: cover property (s_axi_bvalid && s_axi_bresp != 2'h0);

endmodule : dpc_config_bank

// [test/tb.sv]
// Self-checking bench for the digital path configuration bank.
// Assumes the bank checks its own timing with built-in assertions.
`timescale 1ns/10ps
module tb;
   logic        core_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready, pathInclude;
   logic        decimatorEnable, decimationBypass, realDecimation;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, ncoWordA, ncoWordB, rdVal, w;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, outputResolution, rs;
   logic [2:0]  decimationRatio;
   logic [15:0] ncoPhaseIn, ncoPhaseOut;
   logic [19:0] framePattern, pat;
   logic [5:0]  idxs [5] = '{6'h20, 6'h21, 6'h22, 6'h24, 6'h25};
   logic signed [13:0] adcA, adcB, ddcInA, ddcInB;
   int          err_total, cmp_count;

   dpc_config_bank dut (.core_clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .adcA,
      .adcB, .ddcInA, .ddcInB, .pathInclude, .decimatorEnable,
      .decimationRatio, .decimationBypass, .realDecimation, .ncoWordA,
      .ncoWordB, .ncoPhaseIn, .ncoPhaseOut, .outputResolution, .framePattern);

   // Free-running 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic conclude;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask : chk

   // Bounded wait on a ready or valid, sampled mid-cycle where it is settled
   task automatic waitHi(ref logic s);
      int n;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (s !== 1'b1 && n < 60);
      if (s !== 1'b1) begin
         err_total++;
         conclude();
      end
   endtask : waitHi

   // Address and data offered together; design takes both at one edge
   task automatic wr(input logic [5:0] i, input logic [31:0] d);
      @(posedge core_clk);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_awaddr  <= {i, 2'b00};
      s_axi_wdata   <= d;
      s_axi_bready  <= 1'b1;
      waitHi(s_axi_awready);
      @(posedge core_clk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid  <= 1'b0;
      waitHi(s_axi_bvalid);
      rs = s_axi_bresp;
      @(posedge core_clk);
      s_axi_bready <= 1'b0;
   endtask : wr

   // Frame pattern spread over its three byte registers
   task automatic wrPat(input logic [19:0] p);
      wr(6'h20, {24'h0, p[7:0]});
      wr(6'h21, {24'h0, p[15:8]});
      wr(6'h22, {28'h0, p[19:16]});
   endtask : wrPat

   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr  <= a;
      s_axi_rready  <= 1'b1;
      waitHi(s_axi_arready);
      @(posedge core_clk);
      s_axi_arvalid <= 1'b0;
      waitHi(s_axi_rvalid);
      rdVal = s_axi_rdata;
      rs    = s_axi_rresp;
      @(posedge core_clk);
      s_axi_rready <= 1'b0;
   endtask : rd

   // Let a config or sample change reach the outputs before looking
   task automatic settle;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
   endtask : settle

   function automatic logic [31:0] autoPat(input logic [1:0] r);
      case (r)
         2'b00:   return 32'hFE000;
         2'b01:   return 32'hFF000;
         2'b10:   return 32'hFF800;
         default: return 32'hFFC00;
      endcase
   endfunction : autoPat

   // m: [3] mux enable, [2] average, [1:0] selector
   function automatic logic [31:0] route(input logic [3:0] m,
                                         input logic signed [13:0] a, b);
      logic signed [14:0] s;
      s = (a + b) >>> 1;
      if (!m[3] || m[1:0] == 2'b00) return {4'h0, a, b};
      if (m[1:0] == 2'b01) return {4'h0, a, a};
      if (m[1:0] == 2'b10) return {4'h0, b, b};
      return m[2] ? {4'h0, s[13:0], s[13:0]} : {4'h0, a, a};
   endfunction : route

   // Main sequence
   initial begin
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, outputResolution} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      {adcA, adcB, ncoPhaseIn} = 44'h0;
      s_axi_wstrb = 4'hF;
      err_total = 0;
      cmp_count = 0;
      void'($urandom(43570));
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rd({idxs[i], 2'b00});
         chk(rdVal, 32'h0);
         w = 32'($urandom() & 32'hFF);
         wr(idxs[i], w);
         rd({idxs[i], 2'b00});
         chk(rdVal, w);
      end
      rd(8'hFC);
      chk(32'(rs), 32'h2);
      chk(rdVal, 32'h0);
      wr(6'h3F, 32'hFF);
      chk(32'(rs), 32'h2);
      pat = 20'($urandom());
      wrPat(pat);
      wr(6'h24, 32'h06);
      wr(6'h25, 32'h10);
      settle();
      chk(32'(framePattern), 32'(pat));
      chk({30'h0, pathInclude, decimatorEnable}, 32'h3);
      wr(6'h25, 32'h00);
      for (int r = 0; r < 4; r++) begin
         @(posedge core_clk);
         outputResolution <= 2'(r);
         settle();
         chk(32'(framePattern), autoPat(2'(r)));
      end
      // Software patterns for real and complex decimation at 20 bits
      wr(6'h25, 32'h18);
      wrPat(20'hFFC00);
      settle();
      chk(32'(framePattern), 32'hFFC00);
      wr(6'h25, 32'h10);
      wrPat(20'hFFFFF);
      settle();
      chk(32'(framePattern), 32'hFFFFF);
      for (int c = 0; c < 8; c++) begin
         wr(6'h25, 32'(c << 4));
         settle();
         chk(32'(decimationRatio), (c < 6) ? 32'(c) : 32'h0);
         chk(32'(decimationBypass), 32'(c == 0 || c > 5));
      end
      w = $urandom();
      wr(6'h30, w);
      wr(6'h31, ~w);
      wr(6'h25, 32'h18);
      settle();
      chk(ncoWordA, 32'h0);
      chk(ncoWordB, 32'h0);
      chk(32'(realDecimation), 32'h1);
      wr(6'h25, 32'h10);
      settle();
      chk(ncoWordA, w);
      chk(ncoWordB, ~w);
      chk(32'(realDecimation), 32'h0);
      wr(6'h25, 32'h18);
      wr(6'h30, 32'h0);
      wr(6'h25, 32'h10);
      settle();
      chk(ncoWordA, 32'h0);
      for (int k = 0; k < 2; k++) begin
         wr(6'h25, 32'(8'h10 | k));
         @(posedge core_clk);
         ncoPhaseIn <= 16'($urandom());
         settle();
         chk(32'(ncoPhaseOut), {16'h0, k ? ~ncoPhaseIn : ncoPhaseIn});
      end
      // Every selector code, with and without averaging and mux enable
      for (int m = 0; m < 16; m++) begin
         wr(6'h24, 32'({m[2:0], 3'b110}));
         wr(6'h25, {24'h0, m[3], 7'h10});
         for (int j = 0; j < 3; j++) begin
            @(posedge core_clk);
            adcA <= (j == 0) ? 14'h1FFF : 14'($urandom());
            adcB <= (j == 0) ? 14'h1FFF : 14'($urandom());
            settle();
            chk({4'h0, ddcInA, ddcInB}, route(4'(m), adcA, adcB));
         end
      end
      wr(6'h24, 32'h0A);
      wr(6'h25, 32'h90);
      settle();
      chk({4'h0, ddcInA, ddcInB}, {4'h0, adcA, adcB});
      chk({30'h0, pathInclude, decimatorEnable}, 32'h1);
      conclude();
   end
endmodule : tb
